// ---- logic/cfg_bank.sv ----
// pull-up assignment, options and system setup registers on wishbone
// How it works
// - pull-up assignment bits 7 to 4 read zero.
// - each of the g, f and b enable bits switches all pull-ups of its port.
// - port h enable drives pull-ups on 7-4, pull-downs on 3-0.
// - in expanded mode the f and b enables do nothing.
// - master enable off forces every port pull-up off.
// - latch strobe drive bit allows a high drive pulse.
// - port c wired-or bit makes port c outputs open-drain.
// - stretch bit adds one e clock to off-chip accesses.
// - outside single chip, visibility bit shows internal reads.
// - in single chip, visibility bit holds e low, else e runs.
// - bit-order bit selects least significant bit first.
// - extra serial rate bit passes to the rate divider.
// - option bits 1 and 0 read zero.
// - rom placement bit picks high or low rom base.
// - security-off bit disables eeprom security.
// - watchdog disable bit turns the watchdog off.
// - rom enable bit puts rom in the memory map.
// - eeprom enable bit puts eeprom in the memory map.
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "cfg_bank_defs.svh"
module cfg_bank
    import cfg_bank_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output var  logic [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    input  wire logic              single_chip_mode,
    input  wire logic              expanded_mode,
    output pullup_ctl_t            pullup_ctl,
    output bus_ctl_t               bus_ctl,
    output sys_ctl_t               sys_ctl
);
    // ==================================================================
    // storage and mode synchronisers
    logic [7:0]  port_pullup_assignment;
    logic [7:0]  system_options_two;
    logic [7:0]  system_setup_register;
    logic [1:0]  single_sync;
    logic [1:0]  expanded_sync;
    bus_state_t  state;
    bus_state_t  next_state;
    logic [7:0]  next_read;
    logic        do_write;
    logic        single_chip;
    logic        expanded;
    logic        pu_master;
    logic        en_h;
    logic        en_g;
    logic        en_f;
    logic        en_b;

    // mode straps come from pins, two flops before use
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            single_sync   <= 2'h0;
            expanded_sync <= 2'h0;
        end else begin
            single_sync   <= {single_sync[0], single_chip_mode};
            expanded_sync <= {expanded_sync[0], expanded_mode};
        end
    end
    assign single_chip = single_sync[1];
    assign expanded    = expanded_sync[1];

    // ==================================================================
    // wishbone slave: one wait state, ack for one cycle
    always_comb begin
        next_state = bus_idle;
        if (state == bus_idle && wb_cyc_i && wb_stb_i) begin
            next_state = bus_ack;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= bus_idle;
        end else begin
            state <= next_state;
        end
    end
    assign wb_ack_o = (state == bus_ack);
    assign do_write = (state == bus_ack) && wb_we_i && wb_sel_i[0];

    // write effects take hold at the acknowledging edge
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            port_pullup_assignment <= `RST_PULLUP_ASSIGN;
        end else if (do_write && wb_adr_i[7:2] == `IDX_PULLUP_ASSIGN) begin
            port_pullup_assignment <= wb_dat_i[7:0]
                                    & `MASK_PULLUP_ASSIGN;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            system_options_two <= `RST_OPTIONS_TWO;
        end else if (do_write && wb_adr_i[7:2] == `IDX_OPTIONS_TWO) begin
            system_options_two <= wb_dat_i[7:0]
                                & `MASK_OPTIONS_TWO;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            system_setup_register <= `RST_SETUP_REG;
        end else if (do_write && wb_adr_i[7:2] == `IDX_SETUP_REG) begin
            system_setup_register <= (wb_dat_i[7:0] & `MASK_SETUP_REG)
                                   | `ONES_SETUP_REG;
        end
    end

    // read mux; unmapped words read zero and are still acknowledged
    always_comb begin
        next_read = 8'h00;
        if (wb_adr_i[7:2] == `IDX_PULLUP_ASSIGN) begin
            next_read = port_pullup_assignment;
        end else if (wb_adr_i[7:2] == `IDX_OPTIONS_TWO) begin
            next_read = system_options_two;
        end else if (wb_adr_i[7:2] == `IDX_SETUP_REG) begin
            next_read = system_setup_register;
        end
    end

    // read data captured as the ack is raised
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (next_state == bus_ack) begin
            wb_dat_o <= {24'h00_0000, next_read};
        end
    end

    // ==================================================================
    // pull-up gating
    assign pu_master = system_setup_register[`BIT_PU_MASTER];
    assign en_h = pu_master
                & port_pullup_assignment[`BIT_PU_H];
    assign en_g = pu_master
                & port_pullup_assignment[`BIT_PU_G];
    assign en_f = pu_master & ~expanded
                & port_pullup_assignment[`BIT_PU_F];
    assign en_b = pu_master & ~expanded
                & port_pullup_assignment[`BIT_PU_B];

    resistor_map #(
        .PINS (8)
    ) u_map (
        .enable_h (en_h),
        .enable_g (en_g),
        .enable_f (en_f),
        .enable_b (en_b),
        .ctl      (pullup_ctl)
    );

    // ==================================================================
    // external bus controls
    assign bus_ctl.latch_strobe_drive_high =
        system_options_two[`BIT_LATCH_DRIVE];
    assign bus_ctl.port_c_open_drain =
        system_options_two[`BIT_PORTC_OD];
    assign bus_ctl.external_access_stretch =
        system_options_two[`BIT_STRETCH];
    assign bus_ctl.internal_read_visibility = ~single_chip
        & system_options_two[`BIT_VISIBILITY];
    assign bus_ctl.e_pin_hold_low = single_chip
        & system_options_two[`BIT_VISIBILITY];
    assign bus_ctl.e_clock_out_enable = ~bus_ctl.e_pin_hold_low;

    // ==================================================================
    // memory map, watchdog and serial controls
    assign sys_ctl.rom_map_enable =
        system_setup_register[`BIT_ROM_EN];
    assign sys_ctl.rom_base = system_setup_register[`BIT_ROM_PLACE]
        ? `ROM_BASE_HIGH : `ROM_BASE_LOW;
    assign sys_ctl.rom_low_allowed = expanded;
    assign sys_ctl.eeprom_map_enable =
        system_setup_register[`BIT_EEPROM_EN];
    assign sys_ctl.eeprom_security_off =
        system_setup_register[`BIT_SEC_OFF];
    assign sys_ctl.watchdog_disable =
        system_setup_register[`BIT_WDOG_DIS];
    assign sys_ctl.serial_low_bit_first =
        system_options_two[`BIT_SERIAL_LSB];
    assign sys_ctl.serial_rate_extra_bit =
        system_options_two[`BIT_SERIAL_RATE];

    // ==================================================================
    // checks
    a_ack_one_cycle: assert property (@(posedge clock) disable iff (rst)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_after_req: assert property (@(posedge clock) disable iff (rst)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
        else $error("request not acknowledged next cycle");
    a_port_pullup_assignment_high_zero: assert property (@(posedge clock) disable iff (rst)
        port_pullup_assignment[7:4] == 4'h0)
        else $error("pull-up upper bits not zero");
    a_opt_low_zero: assert property (@(posedge clock) disable iff (rst)
        system_options_two[1:0] == 2'h0)
        else $error("option low bits not zero");
    a_setup_ones: assert property (@(posedge clock) disable iff (rst)
        system_setup_register[6:5] == 2'h3)
        else $error("setup bits 6 and 5 not one");
    a_master_off: assert property (@(posedge clock) disable iff (rst)
        !pu_master |-> (pullup_ctl == '0))
        else $error("pull-up active with master off");
    a_expanded_fb: assert property (@(posedge clock) disable iff (rst)
        expanded |-> !pullup_ctl.port_f && !pullup_ctl.port_b)
        else $error("f or b pull-up in expanded mode");
    a_h_split: assert property (@(posedge clock) disable iff (rst)
        en_h |-> pullup_ctl.port_h_up == 8'hF0
              && pullup_ctl.port_h_down == 8'h0F)
        else $error("port h resistor split wrong");
    a_e_hold: assert property (@(posedge clock) disable iff (rst)
        bus_ctl.e_pin_hold_low |-> single_chip
            && !bus_ctl.internal_read_visibility)
        else $error("e hold outside single chip");
    a_write_lands: assert property (@(posedge clock) disable iff (rst)
        (do_write && wb_adr_i[7:2] == `IDX_SETUP_REG)
        |=> sys_ctl.watchdog_disable == $past(wb_dat_i[2]))
        else $error("watchdog disable not written");
endmodule
`default_nettype wire

// ---- logic/cfg_bank_defs.svh ----
// constants for the pull-up and system configuration register bank
`ifndef CFG_BANK_DEFS_SVH
`define CFG_BANK_DEFS_SVH

// ======================================================================
// register byte addresses (the low 8 bits of the byte address)
`define ADDR_PULLUP_ASSIGN   8'h2C
`define ADDR_OPTIONS_TWO     8'h38
`define ADDR_SETUP_REG       8'h3F
// word index of each register (byte address divided by four)
`define IDX_PULLUP_ASSIGN    6'h0B
`define IDX_OPTIONS_TWO      6'h0E
`define IDX_SETUP_REG        6'h0F

// ======================================================================
// writable bit masks, everything else is unimplemented or fixed
`define MASK_PULLUP_ASSIGN   8'h0F
`define MASK_OPTIONS_TWO     8'hFC
`define MASK_SETUP_REG       8'h9F
// bits that always read one in the setup register
`define ONES_SETUP_REG       8'h60

// ======================================================================
// reset values
`define RST_PULLUP_ASSIGN    8'h0F
`define RST_OPTIONS_TWO      8'h00
`define RST_SETUP_REG        8'h6F

// ======================================================================
// field positions
`define BIT_PU_B             0
`define BIT_PU_F             1
`define BIT_PU_G             2
`define BIT_PU_H             3
`define BIT_SERIAL_RATE      2
`define BIT_SERIAL_LSB       3
`define BIT_VISIBILITY       4
`define BIT_STRETCH          5
`define BIT_PORTC_OD         6
`define BIT_LATCH_DRIVE      7
`define BIT_EEPROM_EN        0
`define BIT_ROM_EN           1
`define BIT_WDOG_DIS         2
`define BIT_SEC_OFF          3
`define BIT_PU_MASTER        4
`define BIT_ROM_PLACE        7

// ======================================================================
// rom base addresses
`define ROM_BASE_HIGH        16'h8000
`define ROM_BASE_LOW         16'h0000

`endif

// ---- logic/cfg_bank_pkg.sv ----
// types for the pull-up and system configuration register bank
package cfg_bank_pkg;

    // ==================================================================
    // per-port resistor enables after gating
    typedef struct packed {
        logic [7:0] port_h_up;
        logic [7:0] port_h_down;
        logic       port_g;
        logic       port_f;
        logic       port_b;
    } pullup_ctl_t;

    // ==================================================================
    // external bus and pin controls
    typedef struct packed {
        logic latch_strobe_drive_high;
        logic port_c_open_drain;
        logic external_access_stretch;
        logic internal_read_visibility;
        logic e_pin_hold_low;
        logic e_clock_out_enable;
    } bus_ctl_t;

    // ==================================================================
    // memory map, watchdog and serial controls
    typedef struct packed {
        logic        rom_map_enable;
        logic [15:0] rom_base;
        logic        rom_low_allowed;
        logic        eeprom_map_enable;
        logic        eeprom_security_off;
        logic        watchdog_disable;
        logic        serial_low_bit_first;
        logic        serial_rate_extra_bit;
    } sys_ctl_t;

    // ==================================================================
    // bus slave states
    typedef enum logic [0:0] {
        bus_idle = 1'b0,
        bus_ack  = 1'b1
    } bus_state_t;

endpackage

// ---- logic/resistor_map.sv ----
// maps the gated enables onto per-pin resistor controls
`timescale 1ns/1ps
`default_nettype none
module resistor_map
    import cfg_bank_pkg::*;
#(
    parameter int PINS = 8
) (
    input  wire logic       enable_h,
    input  wire logic       enable_g,
    input  wire logic       enable_f,
    input  wire logic       enable_b,
    output pullup_ctl_t     ctl
);
    // ==================================================================
    // port h: upper half pulls up, lower half pulls down
    genvar i;
    generate
        for (i = 0; i < PINS; i = i + 1) begin : g_pin
            if (i >= PINS / 2) begin : g_up
                assign ctl.port_h_up[i]   = enable_h;
                assign ctl.port_h_down[i] = 1'b0;
            end else begin : g_down
                assign ctl.port_h_up[i]   = 1'b0;
                assign ctl.port_h_down[i] = enable_h;
            end
        end
    endgenerate

    // ==================================================================
    // whole-port enables for the other ports
    assign ctl.port_g = enable_g;
    assign ctl.port_f = enable_f;
    assign ctl.port_b = enable_b;
endmodule
`default_nettype wire

// ---- sim/tb.sv ----
// self-checking bench for the configuration register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
    import cfg_bank_pkg::*;

    // ==================================================================
    // clock, reset and stimulus
    logic        clock;
    logic        rst;
    logic        wb_cyc_i;
    logic        wb_stb_i;
    logic        wb_we_i;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        single_chip_mode;
    logic        expanded_mode;
    pullup_ctl_t pullup_ctl;
    bus_ctl_t    bus_ctl;
    sys_ctl_t    sys_ctl;
    int          errors;
    int          n_compared;
    logic [31:0] q;

    cfg_bank i_cfg_bank (
        .clock            (clock),
        .rst              (rst),
        .wb_cyc_i         (wb_cyc_i),
        .wb_stb_i         (wb_stb_i),
        .wb_we_i          (wb_we_i),
        .wb_adr_i         (wb_adr_i),
        .wb_sel_i         (wb_sel_i),
        .wb_dat_i         (wb_dat_i),
        .wb_dat_o         (wb_dat_o),
        .wb_ack_o         (wb_ack_o),
        .single_chip_mode (single_chip_mode),
        .expanded_mode    (expanded_mode),
        .pullup_ctl       (pullup_ctl),
        .bus_ctl          (bus_ctl),
        .sys_ctl          (sys_ctl)
    );

    // 250 MHz clock
    initial clock = 1'b0;
    always #2 clock = ~clock;

    // ==================================================================
    // reporting
    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, what,
                     got, exp);
        end
    endtask

    // ==================================================================
    // one classic wishbone cycle, held until ack is seen high
    task automatic wb(input logic we, input logic [7:0] adr,
                      input logic [7:0] d, input logic [3:0] sel,
                      output logic [31:0] rd);
        int n;
        n = 0;
        rd = 32'h0;
        @(posedge clock);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= {24'hA5A5A5, d};
        // ack is sampled at the rising edge; read data taken at that edge
        do begin
            @(posedge clock);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1) begin
            errors++;
            $display("unexpected at %0t: no acknowledge", $time);
            give_verdict();
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [7:0] d);
        logic [31:0] dummy;
        wb(1'b1, adr, d, 4'hF, dummy);
    endtask

    task automatic rd_chk(input logic [7:0] adr, input logic [7:0] exp);
        logic [31:0] r;
        wb(1'b0, adr, 8'h00, 4'hF, r);
        chk(r, {24'h0, exp}, "register read");
    endtask

    // mode pins pass a two-flop synchroniser, so allow it to settle
    task automatic set_mode(input logic sc, input logic ex);
        @(posedge clock);
        single_chip_mode <= sc;
        expanded_mode    <= ex;
        repeat (4) @(posedge clock);
        @(negedge clock);
    endtask

    function automatic pullup_ctl_t exp_pu(input logic h, input logic g,
                                           input logic f, input logic b);
        pullup_ctl_t p;
        p.port_h_up   = {{4{h}}, 4'h0};
        p.port_h_down = {4'h0, {4{h}}};
        p.port_g      = g;
        p.port_f      = f;
        p.port_b      = b;
        return p;
    endfunction

    // ==================================================================
    // main sequence
    initial begin
        errors = 0;
        n_compared = 0;
        rst = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i} = 3'b000;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
        single_chip_mode = 1'b0;
        expanded_mode = 1'b0;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        set_mode(1'b0, 1'b0);
        chk(32'(pullup_ctl), 32'h0, "reset pull");
        chk(32'(sys_ctl.rom_base), 32'h0000, "reset rom base");
        rd_chk(8'h2C, 8'h0F);
        rd_chk(8'h38, 8'h00);
        rd_chk(8'h3F, 8'h6F);
        $display("test reset values done");

        // every writable bit set, then every writable option and setup bit cleared
        wr(8'h2C, 8'hFF);
        wr(8'h38, 8'hFF);
        wr(8'h3F, 8'hFF);
        rd_chk(8'h2C, 8'h0F);
        rd_chk(8'h38, 8'hFC);
        rd_chk(8'h3F, 8'hFF);
        @(negedge clock);
        chk(32'(bus_ctl[5:2]), 32'hF, "bus ctl set");
        chk(32'(sys_ctl), 32'(sys_ctl_t'({1'b1, 16'h8000, 1'b0, 5'h1F})),
            "sys ctl set");
        set_mode(1'b1, 1'b0);
        chk(32'(bus_ctl[1:0]), 32'h2, "e pin held");
        wr(8'h38, 8'h00);
        wr(8'h3F, 8'h00);
        rd_chk(8'h3F, 8'h60);
        rd_chk(8'h38, 8'h00);
        @(negedge clock);
        chk(32'(bus_ctl[1:0]), 32'h1, "e clock out");
        chk(32'(sys_ctl), 32'h0, "sys ctl clear");
        set_mode(1'b0, 1'b0);
        chk(32'(bus_ctl[5:2]), 32'h0, "bus ctl clear");
        $display("test option bits done");

        // one port enable at a time, then the master enable off
        wr(8'h3F, 8'h10);
        for (int i = 0; i < 4; i++) begin
            wr(8'h2C, 8'(1 << i));
            @(negedge clock);
            chk(32'(pullup_ctl), 32'(exp_pu(i == 3, i == 2, i == 1, i == 0)),
                "port pull");
        end
        wr(8'h2C, 8'h0F);
        wr(8'h3F, 8'h00);
        @(negedge clock);
        chk(32'(pullup_ctl), 32'h0, "master off");
        wr(8'h3F, 8'h10);
        set_mode(1'b0, 1'b1);
        chk(32'(pullup_ctl), 32'(exp_pu(1, 1, 0, 0)), "expanded");
        chk(32'(sys_ctl.rom_low_allowed), 32'h1, "rom low ok");
        set_mode(1'b0, 1'b0);
        $display("test pull-up gating done");

        // lane zero disabled, and an unmapped word
        wb(1'b1, 8'h2C, 8'h00, 4'hE, q);
        rd_chk(8'h2C, 8'h0F);
        wr(8'h10, 8'hFF);
        rd_chk(8'h10, 8'h00);
        rd_chk(8'h3F, 8'h70);
        $display("test refused writes done");
        give_verdict();
    end
endmodule
`default_nettype wire
